// ===== hdl/adc_input_select_and_fifo_ctrl.sv
// input selection, check-voltage mux, reset/flush commands and fill flag
`timescale 1ns/100ps
module adc_input_select_and_fifo_ctrl (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // parallel write port (pins)
   input wire logic CS_N,
   input wire logic WR_N,
   input wire logic [1:0] RA,
   input wire logic [11:0] DATA_IN,
   // converter core events (same clock)
   input wire logic CONV_TICK,
   input wire logic RESULT_WR,
   input wire logic RESULT_RD,
   // input mux and check-voltage control
   output logic MUX_POS_SE,
   output logic MUX_NEG_SE,
   output logic MUX_DIFF,
   output logic [1:0] CHECK_SEL,
   // queue control
   output logic FIFO_WR_EN,
   output logic FIFO_FLUSH,
   output logic OFFSET_CLR,
   output logic [4:0] FIFO_COUNT,
   output logic RESULTS_READY_FLAG
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [15:0] pin_s1;
   logic [15:0] pin_s2;
   logic wr_n_prev;
   // two flops on every pin, then one more for the strobe edge
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pin_s1 <= 16'hFFFF;
         pin_s2 <= 16'hFFFF;
         wr_n_prev <= 1'b1;
      end else begin
         pin_s1 <= {CS_N, WR_N, RA, DATA_IN};
         pin_s2 <= pin_s1;
         wr_n_prev <= pin_s2[14];
      end
   end

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   // a word is taken on the rising edge of the write strobe, when data is settled
   wire wr_done = pin_s2[14] & ~wr_n_prev & ~pin_s2[15];
   wire [1:0] wr_addr = pin_s2[13:12];
   wire [11:0] wr_data = pin_s2[11:0];
   // addresses 2 and 3 are reserved and silently dropped; no read path exists
   wire wr_in_cfg = wr_done & (wr_addr == adc_cfg_pkg::ADDR_INPUT_CFG);
   wire wr_fifo_cfg = wr_done & (wr_addr == adc_cfg_pkg::ADDR_FIFO_CFG);
   wire cmd_reset = wr_fifo_cfg & wr_data[adc_cfg_pkg::DEVICE_RESET_POS];
   wire cmd_flush = wr_fifo_cfg & wr_data[adc_cfg_pkg::QUEUE_FLUSH_CMD_POS];

   // ----------------------------------------
   // configuration words
   // ----------------------------------------
   logic [11:0] input_and_test_config;
   logic [11:0] fifo_and_reset_config;
   // command bits are never stored, so nothing has to clear them
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         input_and_test_config <= adc_cfg_pkg::INPUT_CFG_RESET;
         fifo_and_reset_config <= adc_cfg_pkg::FIFO_CFG_RESET;
      end else if (cmd_reset) begin
         input_and_test_config <= adc_cfg_pkg::INPUT_CFG_RESET;
         fifo_and_reset_config <= adc_cfg_pkg::FIFO_CFG_RESET;
      end else begin
         if (wr_in_cfg)
            input_and_test_config <= wr_data;
         if (wr_fifo_cfg)
            fifo_and_reset_config <= wr_data & 12'hFFC;
      end
   end

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   wire [4:0] in_field = input_and_test_config[adc_cfg_pkg::SCAN_POS:
                                                adc_cfg_pkg::INPUT_SELECT_LO_POS];
   wire is_pos = (in_field == adc_cfg_pkg::INCFG_POS_SE);
   wire is_neg = (in_field == adc_cfg_pkg::INCFG_NEG_SE);
   wire is_diff = (in_field == adc_cfg_pkg::INCFG_DIFF);
   wire is_scan = (in_field == adc_cfg_pkg::INCFG_SCAN);
   wire [1:0] check_field = input_and_test_config[adc_cfg_pkg::CHECK_VOLTAGE_SELECT_LO_POS +: 2];
   wire [1:0] thr_code = fifo_and_reset_config[adc_cfg_pkg::FILL_THRESHOLD_LO_POS +: 2];
   wire pulse_style = fifo_and_reset_config[adc_cfg_pkg::READY_STYLE_POS];
   wire active_high = fifo_and_reset_config[adc_cfg_pkg::READY_POLARITY_POS];
   // the scan feeds two results per conversion pair, so it uses the second column
   wire [4:0] thr_one = (thr_code == 2'h0) ? adc_cfg_pkg::THR1_0 :
                        (thr_code == 2'h1) ? adc_cfg_pkg::THR1_1 :
                        (thr_code == 2'h2) ? adc_cfg_pkg::THR1_2 : adc_cfg_pkg::THR1_3;
   wire [4:0] thr_two = (thr_code == 2'h0) ? adc_cfg_pkg::THR2_0 :
                        (thr_code == 2'h1) ? adc_cfg_pkg::THR2_1 :
                        (thr_code == 2'h2) ? adc_cfg_pkg::THR2_2 : adc_cfg_pkg::THR2_3;
   wire [4:0] threshold = is_scan ? thr_two : thr_one;

   // ----------------------------------------
   // hold-off after device reset
   // ----------------------------------------
   typedef enum logic [1:0] {ST_RUN = 2'b01, ST_HOLD = 2'b10} hold_state_t;
   hold_state_t state;
   hold_state_t next_state;
   logic [2:0] hold_cnt;
   wire [2:0] next_hold_cnt = cmd_reset ? adc_cfg_pkg::HOLD_TICKS :
                              (state == ST_HOLD && CONV_TICK) ? hold_cnt - 3'h1 : hold_cnt;
   // leave hold once the fifth conversion tick has been seen
   always_comb begin
      case (state)
         ST_RUN: next_state = cmd_reset ? ST_HOLD : ST_RUN;
         ST_HOLD: next_state = (!cmd_reset && CONV_TICK && hold_cnt == 3'h1) ? ST_RUN : ST_HOLD;
         default: next_state = ST_RUN;
      endcase
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state <= ST_RUN;
         hold_cnt <= 3'h0;
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
      end
   end

   // ----------------------------------------
   // result count and scan alternation
   // ----------------------------------------
   logic [4:0] count;
   logic scan_neg;
   logic below;
   wire accept = RESULT_WR & (state == ST_RUN) & ~cmd_reset & ~cmd_flush;
   wire do_inc = accept & (count != 5'(adc_cfg_pkg::QUEUE_DEPTH));
   wire do_dec = RESULT_RD & (count != 5'h00);
   wire [4:0] next_count = (cmd_reset | cmd_flush) ? 5'h00 :
                           count + {4'h0, do_inc} - {4'h0, do_dec};
   wire reached = (next_count >= threshold);
   // the scan restarts on positive after any input_and_test_config write or reset
   wire next_scan_neg = (!is_scan || cmd_reset || wr_in_cfg) ? 1'b0 : scan_neg ^ accept;
   wire next_flag_on = pulse_style ? (reached & below) : reached;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count <= 5'h00;
         scan_neg <= 1'b0;
         below <= 1'b1;
      end else begin
         count <= next_count;
         scan_neg <= next_scan_neg;
         below <= ~reached;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         MUX_POS_SE <= 1'b0;
         MUX_NEG_SE <= 1'b0;
         MUX_DIFF <= 1'b1;
         CHECK_SEL <= 2'h0;
         FIFO_WR_EN <= 1'b0;
         FIFO_FLUSH <= 1'b0;
         OFFSET_CLR <= 1'b0;
         FIFO_COUNT <= 5'h00;
         RESULTS_READY_FLAG <= 1'b0;
      end else begin
         MUX_POS_SE <= is_pos | (is_scan & ~next_scan_neg);
         MUX_NEG_SE <= is_neg | (is_scan & next_scan_neg);
         MUX_DIFF <= is_diff;
         CHECK_SEL <= check_field;
         FIFO_WR_EN <= accept;
         FIFO_FLUSH <= cmd_reset | cmd_flush;
         OFFSET_CLR <= cmd_reset;
         FIFO_COUNT <= next_count;
         RESULTS_READY_FLAG <= next_flag_on ~^ active_high;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   property p_reset_restores; cmd_reset |=> input_and_test_config == adc_cfg_pkg::INPUT_CFG_RESET
      && fifo_and_reset_config == adc_cfg_pkg::FIFO_CFG_RESET; endproperty
   a_reset_restores: assert property (p_reset_restores) else $error("reset left words set");
   property p_reset_clears; cmd_reset |=> FIFO_COUNT == 5'h00 && OFFSET_CLR && FIFO_FLUSH;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");
   property p_hold_off; cmd_reset |=> state == ST_HOLD && hold_cnt == adc_cfg_pkg::HOLD_TICKS;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold-off not armed");
   property p_no_early_write; state == ST_HOLD |=> !FIFO_WR_EN; endproperty
   a_no_early_write: assert property (p_no_early_write) else $error("write during hold");
   property p_flush_keeps; cmd_flush && !cmd_reset |=> FIFO_COUNT == 5'h00
      && $stable(input_and_test_config); endproperty
   a_flush_keeps: assert property (p_flush_keeps) else $error("flush misbehaved");
   property p_static_level; !pulse_style && active_high && $stable(fifo_and_reset_config)
      |=> RESULTS_READY_FLAG == (FIFO_COUNT >= $past(threshold)); endproperty
   a_static_level: assert property (p_static_level) else $error("level flag wrong");
   property p_scan_thr; is_scan && thr_code == 2'h3 |-> threshold == 5'h0C; endproperty
   a_scan_thr: assert property (p_scan_thr) else $error("scan threshold wrong");
   property p_diff_sel; is_diff |=> MUX_DIFF && !MUX_POS_SE && !MUX_NEG_SE; endproperty
   a_diff_sel: assert property (p_diff_sel) else $error("differential select wrong");
   property p_scan_alt; is_scan && accept && !scan_neg && !wr_in_cfg && !cmd_reset
      |=> MUX_NEG_SE && !MUX_POS_SE; endproperty
   a_scan_alt: assert property (p_scan_alt) else $error("scan did not alternate");
   c_reset_hold: cover property (cmd_reset ##1 state == ST_HOLD [*3] ##1 state == ST_HOLD);
   c_pulse_flag: cover property (pulse_style && next_flag_on);
   c_scan_full: cover property (is_scan && count == 5'h0C);
endmodule : adc_input_select_and_fifo_ctrl

// ===== inc/adc_cfg_pkg.sv
// constants for the converter input-select and queue-control block
package adc_cfg_pkg;
   // ----------------------------------------
   // word addressing and widths
   // ----------------------------------------
   localparam int WORD_W = 12;
   localparam logic [1:0] ADDR_INPUT_CFG = 2'h0;
   localparam logic [1:0] ADDR_FIFO_CFG = 2'h1;
   // ----------------------------------------
   // input_and_test_config fields
   // ----------------------------------------
   localparam int INPUT_SELECT_LO_POS = 3;
   localparam int INPUT_SELECT_HI_POS = 4;
   localparam int PAIRED_INPUT_CONFIG_LO_POS = 5;
   localparam int PAIRED_INPUT_CONFIG_HI_POS = 6;
   localparam int SCAN_POS = 7;
   localparam int CHECK_VOLTAGE_SELECT_LO_POS = 8;
   localparam logic [4:0] INCFG_POS_SE = 5'h00;
   localparam logic [4:0] INCFG_NEG_SE = 5'h01;
   localparam logic [4:0] INCFG_DIFF = 5'h04;
   localparam logic [4:0] INCFG_SCAN = 5'h11;
   localparam logic [11:0] INPUT_CFG_RESET = 12'h020;
   // ----------------------------------------
   // fifo_and_reset_config fields
   // ----------------------------------------
   localparam int DEVICE_RESET_POS = 0;
   localparam int QUEUE_FLUSH_CMD_POS = 1;
   localparam int FILL_THRESHOLD_LO_POS = 2;
   localparam int READY_STYLE_POS = 4;
   localparam int READY_POLARITY_POS = 5;
   localparam logic [11:0] FIFO_CFG_RESET = 12'h030;
   // ----------------------------------------
   // queue depth, thresholds, hold-off
   // ----------------------------------------
   localparam int QUEUE_DEPTH = 16;
   localparam logic [4:0] THR1_0 = 5'h01;
   localparam logic [4:0] THR1_1 = 5'h04;
   localparam logic [4:0] THR1_2 = 5'h08;
   localparam logic [4:0] THR1_3 = 5'h0E;
   localparam logic [4:0] THR2_0 = 5'h02;
   localparam logic [4:0] THR2_1 = 5'h04;
   localparam logic [4:0] THR2_2 = 5'h08;
   localparam logic [4:0] THR2_3 = 5'h0C;
   localparam logic [2:0] HOLD_TICKS = 3'h5;
endpackage : adc_cfg_pkg

// ===== testbench/host_bus_model.sv
// host processor model: writes the two control words over the parallel pins
`timescale 1ns/100ps
module host_bus_model (
   // clock
   input wire logic clk,
   // parallel write pins
   output logic cs_n,
   output logic wr_n,
   output logic [1:0] ra,
   output logic [11:0] data_in
);
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      ra = 2'h0;
      data_in = 12'h000;
   end
   // write-only access: the host has no read cycle for these words
   task automatic write_word(input logic [1:0] addr, input logic [11:0] word);
      @(negedge clk);
      cs_n = 1'b0;
      ra = addr;
      data_in = word;
      @(negedge clk);
      wr_n = 1'b0;
      repeat (2) @(negedge clk);
      wr_n = 1'b1;
      // data held past the synchroniser delay of the strobe
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      // released bus shows the inverse so a stale word never looks valid
      data_in = ~word;
      ra = ~addr;
      repeat (2) @(negedge clk);
   endtask : write_word
endmodule : host_bus_model

// ===== testbench/testbench.sv
// self-checking bench for the input-select and queue-control block
`timescale 1ns/100ps
module testbench;
   logic clk, nrst, conv_tick, result_wr, result_rd, cs_n, wr_n;
   logic mux_pos_se, mux_neg_se, mux_diff, fifo_wr_en, fifo_flush, offset_clr, flag;
   logic [1:0] ra, check_sel;
   logic [11:0] data_in;
   logic [4:0] fifo_count;
   logic [2:0] mux;
   int fail_count = 0, n_compared = 0, cycles = 0, low_cycles = 0, off_cycles = 0;
   int flush_cycles = 0;
   assign mux = {mux_pos_se, mux_neg_se, mux_diff};
   adc_input_select_and_fifo_ctrl u_adc_input_select_and_fifo_ctrl (.CLK(clk), .NRST(nrst),
      .CS_N(cs_n), .WR_N(wr_n), .RA(ra), .DATA_IN(data_in), .CONV_TICK(conv_tick),
      .RESULT_WR(result_wr), .RESULT_RD(result_rd), .MUX_POS_SE(mux_pos_se),
      .MUX_NEG_SE(mux_neg_se), .MUX_DIFF(mux_diff), .CHECK_SEL(check_sel),
      .FIFO_WR_EN(fifo_wr_en), .FIFO_FLUSH(fifo_flush), .OFFSET_CLR(offset_clr),
      .FIFO_COUNT(fifo_count), .RESULTS_READY_FLAG(flag));
   host_bus_model u_host_bus_model (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .ra(ra),
      .data_in(data_in));
   // ----------------------------------------
   // clock, cycle ceiling and pulse counters
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) begin
      cycles++;
      low_cycles += int'(flag === 1'b0);
      off_cycles += int'(offset_clr === 1'b1);
      flush_cycles += int'(fifo_flush === 1'b1);
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one result push; the accept pulse may land in either of two cycles
   task automatic push(output logic seen);
      @(negedge clk);
      result_wr = 1'b1;
      @(negedge clk);
      result_wr = 1'b0;
      seen = fifo_wr_en;
      @(negedge clk);
      seen = seen | fifo_wr_en;
   endtask : push
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk);
         conv_tick = 1'b1;
         @(negedge clk);
         conv_tick = 1'b0;
      end
   endtask : tick
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_inputs();
      logic [4:0] code [5] = '{5'h00, 5'h01, 5'h04, 5'h11, 5'h01};
      logic [2:0] exp [5] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h2};
      check("mux", 3'h1, mux);
      check("flag", 1'h0, flag);
      tick(5);
      // legal codes only; scan followed by negative shows the scan phase is dropped
      for (int i = 0; i < 5; i++) begin
         u_host_bus_model.write_word(2'h0, {4'h0, code[i], 3'h0});
         check("mux", exp[i], mux);
      end
      // a word sent to an unused address must leave the selection alone
      u_host_bus_model.write_word(2'h2, 12'h020);
      check("mux", 3'h2, mux);
      for (int i = 0; i < 4; i++) begin
         u_host_bus_model.write_word(2'h0, {2'h0, i[1:0], 8'h00});
         check("check_sel", i[1:0], check_sel);
      end
      $display("test inputs done");
   endtask : t_inputs
   task automatic t_thresh();
      logic [4:0] thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
      logic s;
      for (int t = 0; t < 4; t++) begin
         // flush with static active-high flag and the next threshold code
         u_host_bus_model.write_word(2'h1, {6'h00, 2'h2, t[1:0], 2'h2});
         check("count", 5'h00, fifo_count);
         check("mux", 3'h4, mux);
         for (int k = 1; k <= int'(thr[t]); k++) begin
            push(s);
            check("accept", 1'h1, s);
            check("flag", (k == int'(thr[t])) ? 1'h1 : 1'h0, flag);
         end
         check("count", thr[t], fifo_count);
      end
      $display("test thresholds done");
   endtask : t_thresh
   task automatic t_scan();
      logic s;
      u_host_bus_model.write_word(2'h1, 12'h022);
      u_host_bus_model.write_word(2'h0, 12'h088);
      check("mux", 3'h4, mux);
      push(s);
      check("mux", 3'h2, mux);
      check("flag", 1'h0, flag);
      push(s);
      check("mux", 3'h4, mux);
      check("flag", 1'h1, flag);
      $display("test scan done");
   endtask : t_scan
   task automatic t_pulse();
      int base;
      logic s;
      u_host_bus_model.write_word(2'h1, 12'h012);
      u_host_bus_model.write_word(2'h0, 12'h300);
      check("flag", 1'h1, flag);
      base = low_cycles;
      push(s);
      push(s);
      check("pulses", 5'h01, 5'(low_cycles - base));
      $display("test pulse done");
   endtask : t_pulse
   task automatic t_soft();
      int base;
      int fbase;
      logic s;
      base = off_cycles;
      fbase = flush_cycles;
      u_host_bus_model.write_word(2'h1, 12'h001);
      check("mux", 3'h1, mux);
      check("check_sel", 2'h0, check_sel);
      check("count", 5'h00, fifo_count);
      check("offset_clr", 5'h01, 5'(off_cycles - base));
      check("flush", 5'h01, 5'(flush_cycles - fbase));
      push(s);
      check("accept", 1'h0, s);
      tick(4);
      push(s);
      check("accept", 1'h0, s);
      tick(1);
      @(negedge clk);
      result_wr = 1'b1;
      @(negedge clk);
      result_wr = 1'b0;
      // the default flag is a pulse, so it is looked at in the one cycle it stands
      check("accept", 1'h1, fifo_wr_en);
      check("flag", 1'h1, flag);
      @(negedge clk);
      check("flag", 1'h0, flag);
      result_rd = 1'b1;
      @(negedge clk);
      result_rd = 1'b0;
      @(negedge clk);
      check("count", 5'h00, fifo_count);
      check("flag", 1'h0, flag);
      $display("test soft reset done");
   endtask : t_soft
   initial begin
      nrst = 1'b0;
      conv_tick = 1'b0;
      result_wr = 1'b0;
      result_rd = 1'b0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      t_inputs();
      t_thresh();
      t_scan();
      t_pulse();
      t_soft();
      tally_and_finish();
   end
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
endmodule : testbench
